/* hw/spi_port_defs.vh */
// register map, field positions, control register reset value and timing counts of the serial port
// assumes an 8-bit register port and a 100 MHz system clock
`ifndef SPI_PORT_DEFS_VH
`define SPI_PORT_DEFS_VH

`define SPI_CTRL_OFS   8'h0d
`define SPI_STAT_OFS   8'h0e
`define SPI_DATA_OFS   8'h0f
`define SPI_EVT_OFS    8'h10
`define SPI_MASK_OFS   8'h11

`define SPI_CTRL_RST   8'h00
`define SPI_BIT_IRQEN  7
`define SPI_BIT_EN     6
`define SPI_BIT_LSB    5
`define SPI_BIT_MST    4
`define SPI_BIT_CLOCK_IDLE_POLARITY   3
`define SPI_BIT_CLOCK_SAMPLE_PHASE   2
`define SPI_BIT_DONE   7
`define SPI_BIT_WRITE_COLLISION_FLAG   6

`define SPI_EVT_DONE   0
`define SPI_EVT_WRITE_COLLISION_FLAG   1
`define SPI_EVT_FAULT  2

`define SPI_HALF_DIV4   7'h02
`define SPI_HALF_DIV16  7'h08
`define SPI_HALF_DIV64  7'h20
`define SPI_HALF_DIV128 7'h40
`define SPI_LAST_EDGE   5'h0f

`endif

/* hw/spi_port.v */
// byte-wide serial port, master or slave, with register port and interrupt
// assumes all inputs synchronous to CLK_SYS; pins resolved outside from the enables
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_defs.vh"

module spi_port (
  input  wire       CLK_SYS,
  input  wire       RST,
  input  wire       CE,
  input  wire [7:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output wire [7:0] RDATA,
  input  wire       GIE,
  input  wire       VECTOR_ACK,
  output wire       IRQ,
  input  wire       SCK_I,
  output wire       SCK_O,
  output wire       SCK_OE,
  input  wire       MOSI_I,
  output wire       MOSI_O,
  output wire       MOSI_OE,
  input  wire       MISO_I,
  output wire       MISO_O,
  output wire       MISO_OE,
  input  wire       SS_N_I,
  input  wire       SS_IS_INPUT
);

  reg [7:0] ctrl_reg;
  reg       done_reg;
  reg       write_collision_flag_reg;
  reg       armed_reg;
  reg [2:0] evt_reg;
  reg [2:0] mask_reg;
  reg [7:0] rxbuf_reg;
  reg [7:0] shr_reg;
  reg       out_reg;
  reg [4:0] edge_reg;
  reg       busy_reg;
  reg [6:0] div_reg;
  reg       sck_reg;
  reg       sck_prev_reg;
  reg       sck_oe_reg;
  reg       mosi_oe_reg;
  reg       miso_oe_reg;
  reg [7:0] rdata_reg;
  reg       irq_reg;

  wire en  = ctrl_reg[`SPI_BIT_EN];
  wire mst = ctrl_reg[`SPI_BIT_MST];
  wire lsb = ctrl_reg[`SPI_BIT_LSB];
  wire clock_idle_polarity = ctrl_reg[`SPI_BIT_CLOCK_IDLE_POLARITY];
  wire clock_sample_phase = ctrl_reg[`SPI_BIT_CLOCK_SAMPLE_PHASE];

  reg [6:0] half;
  always @* begin
    case (ctrl_reg[1:0])
      2'b00:   half = `SPI_HALF_DIV4;
      2'b01:   half = `SPI_HALF_DIV16;
      2'b10:   half = `SPI_HALF_DIV64;
      2'b11:   half = `SPI_HALF_DIV128;
      default: half = `SPI_HALF_DIV4;
    endcase
  end

  // selected slave follows the far clock; unselected one never sees it
  wire slv_sel  = en & ~mst & ~SS_N_I;
  wire fault    = en & mst & SS_IS_INPUT & ~SS_N_I;
  wire m_tick   = busy_reg & mst & (div_reg == half - 7'h01);
  wire s_edge   = slv_sel & (SCK_I != sck_prev_reg);
  wire do_edge  = en & (m_tick | s_edge);
  wire sample   = (edge_reg[0] == clock_sample_phase);
  wire in_bit   = mst ? MISO_I : MOSI_I;
  wire [7:0] shr_shift = lsb ? {in_bit, shr_reg[7:1]} : {shr_reg[6:0], in_bit};
  wire first_bit = lsb ? WDATA[0] : WDATA[7];

  wire data_hit = (ADDR == `SPI_DATA_OFS);
  wire data_wr  = WR & data_hit;
  wire data_acc = (WR | RD) & data_hit;
  wire last     = do_edge & (edge_reg == `SPI_LAST_EDGE);

  always @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl_reg     <= `SPI_CTRL_RST;
      done_reg     <= 1'b0;
      write_collision_flag_reg     <= 1'b0;
      armed_reg    <= 1'b0;
      evt_reg      <= 3'h0;
      mask_reg     <= 3'h0;
      rxbuf_reg    <= 8'h00;
      shr_reg      <= 8'h00;
      out_reg      <= 1'b0;
      edge_reg     <= 5'h00;
      busy_reg     <= 1'b0;
      div_reg      <= 7'h00;
      sck_reg      <= 1'b0;
      sck_prev_reg <= 1'b0;
      sck_oe_reg   <= 1'b0;
      mosi_oe_reg  <= 1'b0;
      miso_oe_reg  <= 1'b0;
      rdata_reg    <= 8'h00;
      irq_reg      <= 1'b0;
    end else if (CE) begin
      sck_prev_reg <= SCK_I;
      rdata_reg    <= 8'h00;

      // register reads
      if (RD) begin
        case (ADDR)
          `SPI_CTRL_OFS: rdata_reg <= ctrl_reg;
          `SPI_STAT_OFS: rdata_reg <= {done_reg, write_collision_flag_reg, 6'h00};
          `SPI_DATA_OFS: rdata_reg <= rxbuf_reg;
          `SPI_EVT_OFS:  rdata_reg <= {5'h00, evt_reg};
          `SPI_MASK_OFS: rdata_reg <= {5'h00, mask_reg};
          default:       rdata_reg <= 8'h00;
        endcase
      end

      // clear sequence: status read with a flag up, then any data access
      if (RD & (ADDR == `SPI_STAT_OFS) & (done_reg | write_collision_flag_reg))
        armed_reg <= 1'b1;
      if (data_acc & armed_reg) begin
        armed_reg <= 1'b0;
        done_reg  <= 1'b0;
        write_collision_flag_reg  <= 1'b0;
      end
      if (VECTOR_ACK)
        done_reg <= 1'b0;

      if (WR & (ADDR == `SPI_CTRL_OFS))
        ctrl_reg <= WDATA;
      if (WR & (ADDR == `SPI_MASK_OFS))
        mask_reg <= WDATA[2:0];

      // data write: refused while shifting, else loads the ring
      if (data_wr) begin
        if (busy_reg) begin
          write_collision_flag_reg <= 1'b1;
        end else begin
          shr_reg  <= WDATA;
          out_reg  <= first_bit;
          edge_reg <= 5'h00;
          if (en & mst) begin
            busy_reg <= 1'b1;
            div_reg  <= 7'h00;
          end
        end
      end

      // master clock generator
      if (busy_reg & mst) begin
        if (m_tick) begin
          div_reg <= 7'h00;
          sck_reg <= ~sck_reg;
        end else begin
          div_reg <= div_reg + 7'h01;
        end
      end else begin
        sck_reg <= clock_idle_polarity;
      end

      // shift engine shared by both modes
      if (do_edge) begin
        edge_reg <= edge_reg + 5'h01;
        if (~mst)
          busy_reg <= 1'b1;
        if (sample)
          shr_reg <= shr_shift;
        else
          out_reg <= lsb ? shr_reg[0] : shr_reg[7];
        if (last) begin
          busy_reg  <= 1'b0;
          edge_reg  <= 5'h00;
          rxbuf_reg <= sample ? shr_shift : shr_reg;
          done_reg  <= 1'b1;
        end
      end

      // slave deselected mid-byte: drop the partial transfer
      if (~mst & SS_N_I & busy_reg) begin
        busy_reg <= 1'b0;
        edge_reg <= 5'h00;
      end

      // mode fault wins over a software write of the control register
      if (fault) begin
        ctrl_reg[`SPI_BIT_MST] <= 1'b0;
        done_reg <= 1'b1;
        busy_reg <= 1'b0;
        edge_reg <= 5'h00;
      end

      // sticky event copies, write one to clear, a new event wins
      evt_reg <= (evt_reg & ~((WR & (ADDR == `SPI_EVT_OFS)) ? WDATA[2:0] : 3'h0))
               | {fault, data_wr & busy_reg, last};

      sck_oe_reg  <= en & mst & ~fault;
      mosi_oe_reg <= en & mst & ~fault;
      miso_oe_reg <= slv_sel;
      // global enable gates only the done request, the event mask path is separate
      irq_reg <= (done_reg & ctrl_reg[`SPI_BIT_IRQEN] & GIE) | (|(evt_reg & mask_reg));
    end
  end

  assign RDATA   = rdata_reg;
  assign IRQ     = irq_reg;
  assign SCK_O   = sck_reg;
  assign SCK_OE  = sck_oe_reg;
  assign MOSI_O  = out_reg;
  assign MOSI_OE = mosi_oe_reg;
  assign MISO_O  = out_reg;
  assign MISO_OE = miso_oe_reg;

endmodule // spi_port
`default_nettype wire

/* bench/spi_port_checker.sv */
// pin and read-port checks for the serial port
// bound to spi_port, sees only its ports
`timescale 1ns/1ps
`default_nettype none
module spi_port_checker (
  input wire logic       CLK_SYS,
  input wire logic       RST,
  input wire logic       RD,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] RDATA,
  input wire logic       SCK_O,
  input wire logic       SCK_OE,
  input wire logic       MOSI_OE,
  input wire logic       MISO_OE,
  input wire logic       SS_N_I,
  input wire logic       SS_IS_INPUT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("rdata");
  AST_STAT_RSVD: assert property ($past(RD) && $past(ADDR) == 8'h0e |->
    RDATA[5:0] == 6'h00) else $error("status");
  AST_PIN_DIR: assert property (SCK_OE == MOSI_OE) else $error("pin dir");
  AST_ONE_ROLE: assert property (!(SCK_OE && MISO_OE)) else $error("role");
  AST_UNSEL: assert property (SS_N_I && $past(SS_N_I) |-> !MISO_OE) else $error("unsel");
  AST_FAULT: assert property (SCK_OE && SS_IS_INPUT && !SS_N_I |-> ##[1:3] !SCK_OE)
    else $error("fault");
  AST_RATE: assert property (SCK_OE && $changed(SCK_O) |=> $stable(SCK_O))
    else $error("rate");
  AST_CTRL_OE: assert property ($past(RD) && $past(ADDR) == 8'h0d |->
    SCK_OE == (RDATA[6] && RDATA[4])) else $error("enable");
endmodule // spi_port_checker
bind spi_port spi_port_checker chk (.CLK_SYS, .RST, .RD, .ADDR, .RDATA, .SCK_O, .SCK_OE,
  .MOSI_OE, .MISO_OE, .SS_N_I, .SS_IS_INPUT);
`default_nettype wire

/* bench/spi_slave_model.sv */
// far-side slave: one byte shift register on the serial link
// assumes its select falls before the first clock edge of a byte
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       cs_n,
  input  wire logic       clock_sample_phase,
  input  wire logic       lsb,
  input  wire logic [7:0] tx,
  output wire logic       miso,
  output logic      [7:0] rx
);
  int e;
  int k;
  // bit index moves on change edges only
  assign k = (clock_sample_phase ? e + 1 : e) / 2 - clock_sample_phase;
  // deselected line shows the inverse, never a held value
  assign miso = cs_n ^ tx[lsb ? k[2:0] : 3'h7 - k[2:0]];
  always @(negedge cs_n) e = 0;
  always @(sck) if (!cs_n) begin
    e = e + 1;
    if (e[0] ^ clock_sample_phase) rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
  end
endmodule // spi_slave_model
`default_nettype wire

/* bench/spi_port_tb.sv */
// master-mode bench of spi_port against a slave model
// assumes the register map header on the include path
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected %0t got %h want %h", $time, a, e); end end
module spi_port_tb;
  logic       clk = 0, rst = 1, wr_s = 0, rd_s = 0, gie = 0, ss_n = 1, ss_in = 0;
  logic       cs_n = 1, clock_idle_polarity = 0, clock_sample_phase = 0, lsb = 0, ce = 1, vack = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, q, s_tx = 8'h00, m_tx;
  wire        sck, sck_o, sck_oe, mosi, miso, irq;
  wire  [7:0] rdata, s_rx;
  int         fail_count = 0, num_checks = 0, cyc = 0, t0, h;
  logic [7:0] exp_q[$];
  assign sck = sck_oe ? sck_o : clock_idle_polarity;
  spi_port uut (.CLK_SYS(clk), .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .GIE(gie), .VECTOR_ACK(vack), .IRQ(irq), .SCK_I(sck),
    .SCK_O(sck_o), .SCK_OE(sck_oe), .MOSI_I(mosi), .MOSI_O(mosi), .MOSI_OE(),
    .MISO_I(miso), .MISO_O(), .MISO_OE(), .SS_N_I(ss_n), .SS_IS_INPUT(ss_in));
  spi_slave_model peer (.sck(sck), .mosi(mosi), .cs_n(cs_n), .clock_sample_phase(clock_sample_phase), .lsb(lsb),
    .tx(s_tx), .miso(miso), .rx(s_rx));
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  task wr(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'h1;
    @(posedge clk);
    wr_s <= 1'h0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge clk);
    rd_s <= 1'h0;
    #1 q = rdata;
  endtask
  task rc(input logic [7:0] a, e);
    rd(a);
    `CHK(q, e)
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hfa67_1152));
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    rc(8'h0d, 8'h00);
    rc(8'h0e, 8'h00);
    rc(8'h20, 8'h00);
    wr(8'h0d, 8'h10);
    wr(8'h0f, 8'h5a);
    repeat (40) @(posedge clk);
    `CHK(sck_oe, 1'h0)
    rc(8'h0e, 8'h00);
    for (int m = 0; m < 8; m++) begin
      {lsb, clock_idle_polarity, clock_sample_phase} = m[2:0];
      h = (m % 4 == 3) ? 64 : 2 << (2 * (m % 4));
      @(posedge clk) gie <= m[0];
      wr(8'h0d, {2'h3, lsb, 1'h1, clock_idle_polarity, clock_sample_phase, m[1:0]});
      s_tx = $urandom;
      m_tx = $urandom;
      exp_q.push_back(s_tx);
      repeat (2) @(posedge clk);
      cs_n = 0;
      wr(8'h0f, m_tx);
      t0 = cyc;
      wr(8'h0f, ~m_tx);
      q = 8'h00;
      for (int n = 0; n < 600 && !q[7]; n++) rd(8'h0e);
      if (!q[7]) begin
        fail_count++;
        print_verdict;
      end
      `CHK(q, 8'hc0)
      `CHK(cyc - t0 >= 16 * h && cyc - t0 <= 16 * h + 5, 1'b1)
      @(posedge clk);
      `CHK(irq, gie)
      `CHK(sck_o, clock_idle_polarity)
      rc(8'h0f, exp_q.pop_front());
      `CHK(s_rx, m_tx)
      cs_n = 1;
      rc(8'h0e, 8'h00);
      `CHK(irq, 1'h0)
    end
    wr(8'h0d, 8'h50);
    @(posedge clk);
    ss_in <= 1'h1;
    ss_n <= 1'h0;
    repeat (3) @(posedge clk);
    ss_n <= 1'h1;
    rc(8'h0d, 8'h40);
    rc(8'h0e, 8'h80);
    @(posedge clk) vack <= 1'h1;
    @(posedge clk) vack <= 1'h0;
    rc(8'h0e, 8'h00);
    // every transfer, the collisions and the fault left sticky events behind
    rc(8'h10, 8'h07);
    wr(8'h11, 8'h04);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'h1)
    wr(8'h10, 8'h07);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'h0)
    // clock enable low: a control write must be lost
    @(posedge clk) ce <= 1'h0;
    wr(8'h0d, 8'h00);
    @(posedge clk) ce <= 1'h1;
    rc(8'h0d, 8'h40);
    print_verdict;
  end
endmodule // spi_port_tb
`default_nettype wire
